// *** rtl/irq_seq_consts.vh ***
`ifndef IRQ_SEQ_CONSTS_VH
`define IRQ_SEQ_CONSTS_VH

// Register byte offsets
`define REG_FLAGS 8'h00
`define REG_ENABLE 8'h04
`define REG_GLOBAL 8'h08
`define REG_EVT_STATUS 8'h0c
`define REG_EVT_MASK 8'h10
`define REG_STATE 8'h14

// Field positions
`define GLOBAL_EN_BIT 0
`define EVT_ENTRY_BIT 0
`define EVT_RETURN_BIT 1
`define EVT_WAKE_BIT 2
`define EVT_WIDTH 3

// Reset values
`define RST_ENABLE 8'h00
`define RST_EVT_MASK 3'h0

// Timing counts in CPU clock cycles
`define ENTRY_CYCLES 3'h4
`define JUMP_CYCLES 3'h3
`define WAKE_EXTRA_CYCLES 3'h4
`define RETURN_CYCLES 3'h4

// Vector layout
`define VECTOR_STEP 16'h0002

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// *** rtl/interrupt_entry_sequencer.v ***
// What this block does
// - Taking an interrupt clears global enable
// - Global enable set in handler allows nesting
// - Flag cleared by hardware when vectoring
// - Writing one clears flag, zero ignored
// - Disabled flag conditions still latch flag
// - Level sources request only while present
// - One main instruction runs after return
// - Status flags never saved or restored
// - Global disable acts in its own cycle
// - Instruction after global enable runs first
// - Entry lasts four cycles, pushes pointer
// - Vector jump completes in three cycles
// - Multi-cycle instruction finishes before entry
// - Wake from sleep adds four cycles
// - Return pops pointer, adds two, enables
// - Needs own enable and global enable
// - Lowest vector wins, reset highest priority
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "irq_seq_consts.vh"

module interrupt_entry_sequencer #(
    parameter NSRC = 8,
    parameter IW = 3,
    parameter IPW = 16,
    parameter [7:0] LEVEL_MASK = 8'h00,
    parameter [15:0] VECTOR_BASE = 16'h0000
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Peripheral interrupt conditions
    input wire [NSRC-1:0] src_cond,
    // Instruction pipeline
    input wire instr_boundary,
    input wire instr_sei,
    input wire instr_cli,
    input wire return_from_handler_instr,
    input wire core_sleeping,
    input wire startup_done,
    input wire [IPW-1:0] instr_pointer,
    output wire core_hold,
    output wire wake_req,
    output wire vector_load,
    output reg [IPW-1:0] vector_addr,
    output wire handler_start,
    output wire instr_pointer_load,
    output reg [IPW-1:0] instr_pointer_ret,
    // Stack
    output wire stack_push,
    output reg [7:0] stack_wdata,
    output wire stack_pop,
    input wire [7:0] stack_rdata,
    output wire sp_add_two,
    // Interrupt
    output wire irq
);

    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_WAKE = 3'd1;
    localparam [2:0] ST_ENTRY = 3'd2;
    localparam [2:0] ST_JUMP = 3'd3;
    localparam [2:0] ST_RET = 3'd4;

    // Lowest index is lowest vector, so it wins
    function [IW-1:0] first_one;
        input [NSRC-1:0] v;
        integer i;
        begin
            first_one = {IW{1'b0}};
            for (i = NSRC - 1; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    first_one = i[IW-1:0];
                end
            end
        end
    endfunction

    reg [2:0] state_q, state_d;
    reg [2:0] cnt_q, cnt_d;
    reg [NSRC-1:0] flags_q;
    reg [NSRC-1:0] enable_q;
    reg gie_q;
    reg [IW-1:0] sel_q;
    reg [IPW-1:0] ret_q;
    reg ret_exit_q;
    reg [`EVT_WIDTH-1:0] evt_q;
    reg [`EVT_WIDTH-1:0] evt_mask_q;

    // AXI holding registers
    reg aw_full_q, w_full_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;

    wire [NSRC-1:0] level_sel = LEVEL_MASK[NSRC-1:0];
    wire [NSRC-1:0] req;
    wire any_req;
    wire [IW-1:0] pick;
    wire gie_eff;
    wire at_boundary;
    wire take;
    wire wake_take;
    wire do_write;
    wire do_read;
    wire last_cnt;

    // Flag sources from flags, level sources from live condition
    assign req = ((flags_q & ~level_sel) | (src_cond & level_sel))
                 & enable_q;
    assign any_req = |req;
    assign pick = first_one(req);
    // Disable acts combinationally so a same-cycle request is refused
    assign gie_eff = gie_q & ~instr_cli;
    // The sei boundary and the first boundary after return are skipped
    assign at_boundary = instr_boundary & ~instr_sei
                         & ~ret_exit_q;
    assign take = (state_q == ST_IDLE) & ~core_sleeping & at_boundary
                  & gie_eff & any_req;
    assign wake_req = (state_q == ST_IDLE) & core_sleeping
                      & gie_eff & any_req;
    assign wake_take = wake_req & startup_done;

    assign last_cnt = (cnt_q == 3'd0);
    assign core_hold = (state_q != ST_IDLE);
    assign stack_push = (state_q == ST_ENTRY)
                        & (cnt_q == 3'd3 || cnt_q == 3'd2);
    assign vector_load = (state_q == ST_ENTRY) & last_cnt;
    assign handler_start = (state_q == ST_JUMP) & last_cnt;
    assign stack_pop = (state_q == ST_RET)
                       & (cnt_q == 3'd2 || cnt_q == 3'd1);
    assign sp_add_two = (state_q == ST_RET) & last_cnt;
    assign instr_pointer_load = (state_q == ST_RET) & last_cnt;
    // Status flags are not touched here; software keeps them

    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        if (!last_cnt) begin
            cnt_d = cnt_q - 3'd1;
        end
        case (state_q)
            ST_IDLE: begin
                if (wake_take) begin
                    state_d = ST_WAKE;
                    cnt_d = `WAKE_EXTRA_CYCLES - 3'd1;
                end else if (take) begin
                    state_d = ST_ENTRY;
                    cnt_d = `ENTRY_CYCLES - 3'd1;
                end else if (return_from_handler_instr) begin
                    state_d = ST_RET;
                    cnt_d = `RETURN_CYCLES - 3'd1;
                end
            end
            ST_WAKE: begin
                if (last_cnt) begin
                    state_d = ST_ENTRY;
                    cnt_d = `ENTRY_CYCLES - 3'd1;
                end
            end
            ST_ENTRY: begin
                if (last_cnt) begin
                    state_d = ST_JUMP;
                    cnt_d = `JUMP_CYCLES - 3'd1;
                end
            end
            ST_JUMP: begin
                if (last_cnt) begin
                    state_d = ST_IDLE;
                end
            end
            ST_RET: begin
                if (last_cnt) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                cnt_d = 3'd0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            cnt_q <= 3'd0;
            sel_q <= {IW{1'b0}};
            ret_q <= {IPW{1'b0}};
            ret_exit_q <= 1'b0;
            vector_addr <= {IPW{1'b0}};
            instr_pointer_ret <= {IPW{1'b0}};
            stack_wdata <= 8'h00;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            if (state_d == ST_RET && state_q == ST_RET && last_cnt) begin
                ret_exit_q <= 1'b1;
            end else if (state_q == ST_RET && last_cnt) begin
                ret_exit_q <= 1'b1;
            end else if (instr_boundary) begin
                ret_exit_q <= 1'b0;
            end
            if (take | wake_take) begin
                sel_q <= pick;
                ret_q <= instr_pointer;
                stack_wdata <= instr_pointer[7:0];
                // Source i sits i+1 steps above the reset vector
                vector_addr <= VECTOR_BASE + ({{(IPW-IW){1'b0}}, pick}
                               + 16'h0001) * `VECTOR_STEP;
            end
            if (state_q == ST_ENTRY && cnt_q == 3'd3) begin
                stack_wdata <= ret_q[15:8];
            end
            if (stack_pop && cnt_q == 3'd2) begin
                instr_pointer_ret[15:8] <= stack_rdata;
            end
            if (stack_pop && cnt_q == 3'd1) begin
                instr_pointer_ret[7:0] <= stack_rdata;
            end
        end
    end

    // Pending flags: hardware set wins over every clear
    wire [NSRC-1:0] flag_set = src_cond & ~level_sel;
    reg [NSRC-1:0] flag_clr;
    always @* begin
        flag_clr = {NSRC{1'b0}};
        if (take | wake_take) begin
            flag_clr[pick] = 1'b1;
        end
        if (do_write && awaddr_q == `REG_FLAGS && wstrb_q[0]) begin
            flag_clr = flag_clr | wdata_q[NSRC-1:0];
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= {NSRC{1'b0}};
        end else begin
            flags_q <= (flags_q & ~flag_clr) | flag_set;
        end
    end

    // Global enable: entry and cli beat any set in the same cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            gie_q <= 1'b0;
        end else if (take | wake_take) begin
            gie_q <= 1'b0;
        end else if (instr_cli) begin
            gie_q <= 1'b0;
        end else if (sp_add_two | instr_sei) begin
            gie_q <= 1'b1;
        end else if (do_write && awaddr_q == `REG_GLOBAL && wstrb_q[0]) begin
            gie_q <= wdata_q[`GLOBAL_EN_BIT];
        end
    end

    // AXI4-Lite slave, one write and one read at a time
    assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_full_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
    assign do_read = s_axi_arvalid & ~s_axi_rvalid;

    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `REG_FLAGS) || (a == `REG_ENABLE)
                     || (a == `REG_GLOBAL) || (a == `REG_EVT_STATUS)
                     || (a == `REG_EVT_MASK) || (a == `REG_STATE);
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            enable_q <= `RST_ENABLE;
            evt_mask_q <= `RST_EVT_MASK;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
                if (awaddr_q == `REG_ENABLE && wstrb_q[0]) begin
                    enable_q <= wdata_q[NSRC-1:0];
                end
                if (awaddr_q == `REG_EVT_MASK && wstrb_q[0]) begin
                    evt_mask_q <= wdata_q[`EVT_WIDTH-1:0];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Event status: set wins over the clear that a read makes
    wire [`EVT_WIDTH-1:0] evt_set = {wake_take, sp_add_two, vector_load};
    wire evt_rd_clr = do_read
                      && {s_axi_araddr[7:2], 2'b00} == `REG_EVT_STATUS;

    always @(posedge aclk) begin
        if (!aresetn) begin
            evt_q <= {`EVT_WIDTH{1'b0}};
        end else if (evt_rd_clr) begin
            evt_q <= evt_set;
        end else begin
            evt_q <= evt_q | evt_set;
        end
    end

    assign irq = |(evt_q & evt_mask_q);

    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h00000000;
        case ({s_axi_araddr[7:2], 2'b00})
            `REG_FLAGS: rd_mux[NSRC-1:0] = flags_q;
            `REG_ENABLE: rd_mux[NSRC-1:0] = enable_q;
            `REG_GLOBAL: rd_mux[`GLOBAL_EN_BIT] = gie_q;
            `REG_EVT_STATUS: rd_mux[`EVT_WIDTH-1:0] = evt_q;
            `REG_EVT_MASK: rd_mux[`EVT_WIDTH-1:0] = evt_mask_q;
            `REG_STATE: rd_mux = {21'h000000, sel_q, 5'h00, state_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= mapped({s_axi_araddr[7:2], 2'b00}) ?
                           `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // interrupt_entry_sequencer

// *** tb/ies_monitor.sv ***
`timescale 1ns/1ps
module ies_monitor (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Pipeline
    input wire instr_boundary,
    input wire instr_sei,
    input wire instr_cli,
    input wire return_from_handler_instr,
    input wire core_sleeping,
    input wire startup_done,
    input wire core_hold,
    input wire wake_req,
    input wire vector_load,
    input wire handler_start,
    input wire instr_pointer_load,
    // Stack
    input wire stack_push,
    input wire stack_pop,
    input wire sp_add_two
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Two push cycles, one spare, then the vector cycle
    sequence s_push; stack_push[*2] ##2 vector_load; endsequence
    sequence s_jump; !handler_start[*2] ##1 handler_start; endsequence
    sequence s_pop; stack_pop[*2] ##1 (instr_pointer_load && sp_add_two);
    endsequence
    property p_entry; $rose(stack_push) |-> s_push; endproperty
    property p_jump; vector_load |=> s_jump; endproperty
    property p_ret; return_from_handler_instr && !core_hold |-> ##2 s_pop;
    endproperty
    property p_after_ret;
        instr_pointer_load ##1 (instr_boundary && !core_hold)
            |-> ##4 !vector_load;
    endproperty
    property p_cli; instr_cli && !core_hold |-> ##4 !vector_load; endproperty
    property p_sei; instr_sei && !core_hold |-> ##4 !vector_load; endproperty
    // Wake entry keeps the core held right through to the vector
    property p_wake;
        startup_done && wake_req |=> core_hold[*7] ##1 vector_load;
    endproperty
    property p_multi;
        !instr_boundary && !core_hold && !startup_done |-> ##4 !vector_load;
    endproperty
    property p_wreq;
        wake_req |-> core_sleeping && !core_hold && !instr_cli;
    endproperty
    a_entry: assert property (p_entry)
        else $error("entry push or vector out of step");
    a_jump: assert property (p_jump)
        else $error("handler start not three cycles after vector");
    a_ret: assert property (p_ret)
        else $error("return sequence out of step");
    a_after_ret: assert property (p_after_ret)
        else $error("interrupt taken right after return");
    a_cli: assert property (p_cli)
        else $error("interrupt taken in disable cycle");
    a_sei: assert property (p_sei)
        else $error("interrupt taken on enable instruction");
    a_wake: assert property (p_wake)
        else $error("wake entry not eight cycles");
    a_multi: assert property (p_multi)
        else $error("interrupt taken inside an instruction");
    a_wreq: assert property (p_wreq)
        else $error("wake request outside sleep");
endmodule // ies_monitor

// *** tb/cpu_model.sv ***
`timescale 1ns/1ps
module cpu_model (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Pipeline
    input wire slow,
    input wire core_hold,
    output wire instr_boundary,
    // Stack
    input wire stack_push,
    input wire [7:0] stack_wdata,
    input wire stack_pop,
    output wire [7:0] stack_rdata
);
    reg [1:0] cnt_q;
    reg [2:0] ptr_q;
    reg [7:0] mem_q [0:7];
    // Slow mode runs three-cycle instructions
    assign instr_boundary = !core_hold && (!slow || cnt_q == 2'h2);
    // Idle line shows the inverse so stale bytes never pass
    assign stack_rdata = stack_pop ? mem_q[ptr_q - 3'h1]
                                   : ~mem_q[ptr_q - 3'h1];
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 2'h0;
            ptr_q <= 3'h0;
        end else begin
            cnt_q <= (cnt_q == 2'h2 || core_hold) ? 2'h0 : cnt_q + 2'h1;
            if (stack_push) begin
                mem_q[ptr_q] <= stack_wdata;
                ptr_q <= ptr_q + 3'h1;
            end else if (stack_pop) begin
                ptr_q <= ptr_q - 3'h1;
            end
        end
    end
endmodule // cpu_model

// *** tb/interrupt_entry_sequencer_tb.sv ***
`timescale 1ns/1ps
`include "irq_seq_consts.vh"
module interrupt_entry_sequencer_tb;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg [31:0] s_axi_wdata = 32'h0;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, slow = 1'b0;
    reg strb_lo = 1'b1;
    reg [1:0] exp_wr [$];
    reg [7:0] src_cond = 8'h00;
    reg instr_sei = 1'b0, instr_cli = 1'b0, core_sleeping = 1'b0;
    reg return_from_handler_instr = 1'b0, startup_done = 1'b0;
    reg [15:0] instr_pointer = 16'h0, ip_a, ip_b;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, core_hold, wake_req, vector_load, handler_start;
    wire instr_pointer_load, stack_push, stack_pop, sp_add_two, irq;
    wire instr_boundary;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] vector_addr, instr_pointer_ret;
    wire [7:0] stack_wdata, stack_rdata;
    reg [33:0] exp_rd [$];
    reg [15:0] exp_vec [$];
    reg [31:0] seed = 32'h00008c63;
    reg [6:0] r;
    integer num_errors = 0;
    integer total_checks = 0;
    integer i;
    // Bit 7 is the level source, the rest latch flags
    interrupt_entry_sequencer #(.LEVEL_MASK(8'h80))
        interrupt_entry_sequencer_inst (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .src_cond, .instr_boundary,
        .instr_sei, .instr_cli, .return_from_handler_instr, .core_sleeping,
        .startup_done, .instr_pointer, .core_hold, .wake_req, .vector_load,
        .vector_addr, .handler_start, .instr_pointer_load,
        .instr_pointer_ret, .stack_push, .stack_wdata, .stack_pop,
        .stack_rdata, .sp_add_two, .irq);
    cpu_model cpu_model_inst (.aclk, .aresetn, .slow, .core_hold,
        .instr_boundary, .stack_push, .stack_wdata, .stack_pop,
        .stack_rdata);
    always #10 aclk = ~aclk;
    function [31:0] xs(input [31:0] x);
        begin
            x = x ^ (x << 13);
            x = x ^ (x >> 17);
            xs = x ^ (x << 5);
        end
    endfunction
    task cmp(input [33:0] g, input [33:0] e);
        begin
            total_checks = total_checks + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task chk_rd(input [33:0] g);
        if (exp_rd.size() == 0) cmp(34'h1, 34'h0);
        else cmp(g, exp_rd.pop_front());
    endtask
    // An empty queue catches any entry that should not happen
    task chk_vec(input [15:0] g);
        if (exp_vec.size() == 0) cmp(34'h1, 34'h0);
        else cmp({18'h0, g}, {18'h0, exp_vec.pop_front()});
    endtask
    task chk_wr(input [1:0] g);
        if (exp_wr.size() == 0) cmp(34'h1, 34'h0);
        else cmp({32'h0, g}, {32'h0, exp_wr.pop_front()});
    endtask
    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready)
            chk_rd({s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid === 1'b1 && s_axi_bready) chk_wr(s_axi_bresp);
        if (vector_load === 1'b1) chk_vec(vector_addr);
        if (instr_pointer_load === 1'b1) chk_vec(instr_pointer_ret);
    end
    task axi_wr(input [7:0] a, input [31:0] d);
        reg ta, tw, tb;
        begin
            tb = 1'b0;
            exp_wr.push_back((a > `REG_STATE) ? `RESP_SLVERR : `RESP_OKAY);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            // Upper strobe bits are ignored, so they carry noise
            s_axi_wstrb <= {seed[3:1], strb_lo};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            while (!tb) begin
                @(negedge aclk);
                ta = s_axi_awvalid && s_axi_awready;
                tw = s_axi_wvalid && s_axi_wready;
                tb = s_axi_bvalid && s_axi_bready;
                @(posedge aclk);
                if (ta) s_axi_awvalid <= 1'b0;
                if (tw) s_axi_wvalid <= 1'b0;
            end
            s_axi_bready <= 1'b0;
            @(posedge aclk);
        end
    endtask
    task axi_rd(input [7:0] a, input [33:0] e);
        reg ta, tr;
        begin
            exp_rd.push_back(e);
            tr = 1'b0;
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            while (!tr) begin
                @(negedge aclk);
                ta = s_axi_arvalid && s_axi_arready;
                tr = s_axi_rvalid && s_axi_rready;
                @(posedge aclk);
                if (ta) s_axi_arvalid <= 1'b0;
            end
            s_axi_rready <= 1'b0;
            @(posedge aclk);
        end
    endtask
    task wait_hold;
        begin
            do @(negedge aclk); while (core_hold !== 1'b1);
            do @(negedge aclk); while (core_hold !== 1'b0);
            @(posedge aclk);
        end
    endtask
    task pulse_src(input [7:0] m);
        begin
            src_cond <= m;
            @(posedge aclk);
            src_cond <= 8'h00;
        end
    endtask
    task do_ret(input [15:0] e);
        begin
            exp_vec.push_back(e);
            return_from_handler_instr <= 1'b1;
            @(posedge aclk);
            return_from_handler_instr <= 1'b0;
            wait_hold;
        end
    endtask
    task final_report;
        begin
            $display("checks %0d errors %0d", total_checks, num_errors);
            if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial begin
        #100000;
        num_errors = num_errors + 1;
        final_report;
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 5; i = i + 1) axi_rd(i * 4, 34'h0);
        axi_rd(8'h3c, {`RESP_SLVERR, 32'h0});
        axi_wr(8'h3c, 32'hffffffff);
        $display("reset values done");
        seed = xs(seed);
        r = seed[6:0] | 7'h07;
        slow <= seed[8];
        pulse_src({1'b0, r});
        axi_rd(`REG_FLAGS, {27'h0, r});
        axi_wr(`REG_FLAGS, 32'h1);
        axi_rd(`REG_FLAGS, {27'h0, r & 7'h7e});
        $display("flags done");
        seed = xs(seed);
        ip_a = seed[15:0];
        ip_b = seed[31:16];
        instr_pointer <= ip_a;
        slow <= 1'b0;
        axi_wr(`REG_EVT_MASK, 32'h7);
        axi_wr(`REG_ENABLE, 32'hff);
        strb_lo = 1'b0;
        axi_wr(`REG_ENABLE, 32'h0);
        strb_lo = 1'b1;
        axi_rd(`REG_ENABLE, 34'hff);
        exp_vec.push_back(16'h0004);
        axi_wr(`REG_GLOBAL, 32'h1);
        wait_hold;
        instr_pointer <= ip_b;
        axi_rd(`REG_GLOBAL, 34'h0);
        axi_rd(`REG_FLAGS, {27'h0, r & 7'h7c});
        cmp({33'h0, irq}, 34'h1);
        axi_rd(`REG_EVT_STATUS, 34'h1);
        cmp({33'h0, irq}, 34'h0);
        exp_vec.push_back(16'h0006);
        axi_wr(`REG_GLOBAL, 32'h1);
        wait_hold;
        axi_wr(`REG_FLAGS, 32'h7f);
        do_ret(ip_b);
        axi_rd(`REG_GLOBAL, 34'h1);
        axi_wr(`REG_GLOBAL, 32'h0);
        pulse_src(8'h08);
        do_ret(ip_a);
        exp_vec.push_back(16'h0008);
        wait_hold;
        $display("entry and return done");
        axi_wr(`REG_GLOBAL, 32'h1);
        // Flag is pending when the disable arrives
        pulse_src(8'h10);
        instr_cli <= 1'b1;
        @(posedge aclk);
        instr_cli <= 1'b0;
        axi_rd(`REG_GLOBAL, 34'h0);
        axi_rd(`REG_FLAGS, 34'h10);
        exp_vec.push_back(16'h000a);
        instr_sei <= 1'b1;
        @(posedge aclk);
        instr_sei <= 1'b0;
        wait_hold;
        $display("disable and enable done");
        pulse_src(8'h80);
        axi_wr(`REG_GLOBAL, 32'h1);
        repeat (6) @(posedge aclk);
        slow <= 1'b1;
        exp_vec.push_back(16'h0010);
        src_cond <= 8'h80;
        wait_hold;
        src_cond <= 8'h00;
        slow <= 1'b0;
        $display("level source done");
        core_sleeping <= 1'b1;
        axi_wr(`REG_GLOBAL, 32'h1);
        pulse_src(8'h40);
        repeat (2) @(posedge aclk);
        exp_vec.push_back(16'h000e);
        startup_done <= 1'b1;
        @(posedge aclk);
        startup_done <= 1'b0;
        wait_hold;
        core_sleeping <= 1'b0;
        axi_wr(`REG_EVT_MASK, 32'h0);
        cmp({33'h0, irq}, 34'h0);
        axi_rd(`REG_EVT_STATUS, 34'h7);
        cmp(exp_vec.size(), 34'h0);
        $display("sleep and events done");
        final_report;
    end
endmodule // interrupt_entry_sequencer_tb
bind interrupt_entry_sequencer ies_monitor ies_monitor_inst (.aclk,
    .aresetn, .instr_boundary, .instr_sei, .instr_cli,
    .return_from_handler_instr, .core_sleeping, .startup_done, .core_hold,
    .wake_req, .vector_load, .handler_start, .instr_pointer_load,
    .stack_push, .stack_pop, .sp_add_two);
